// ===== rtl/iap_params.svh
/*
 Constants of the independent axis profiler: register map, field
 positions and reset values. Assumes a 9-bit AXI4-Lite byte address.
*/
`ifndef IAP_PARAMS_SVH
`define IAP_PARAMS_SVH
// Operation
// - Every axis profiles alone from own settings
// - Begin builds trapezoid or triangle trajectory
// - New command position each sample tick
// - Done once final position issued
// - Begin names axes; empty mask starts all
// - Speed, accel changeable; decel, target not
// - Stop decelerates axis to rest early
// - Increment adds to target, regenerates profile
// - Idle increment acts as relative plus begin
// - Target readback: destination or command position
// - Readback of rates, speed, relative distance
// - Unreachable speed gives early braking triangle
// - Trapezoid ends exactly on target
// - Wait points for done and in-position
// - Per-axis smoothing time constant
// - Settings by axis list or single axis

// ----------------------------------------------------------
// Per-axis block: axis in addr[7:5], register in addr[4:2]
// ----------------------------------------------------------
`define IAP_R_ABS 3'h0
`define IAP_R_REL 3'h1
`define IAP_R_SPD 3'h2
`define IAP_R_ACC 3'h3
`define IAP_R_DEC 3'h4
`define IAP_R_TC 3'h5
`define IAP_R_INC 3'h6
`define IAP_R_CPOS 3'h7
`define IAP_LIST_AX 3'h4

// ----------------------------------------------------------
// Global registers
// ----------------------------------------------------------
`define IAP_A_CONTROL 9'h100
`define IAP_A_STATUS 9'h104
`define IAP_A_IRQ_STS 9'h108
`define IAP_A_IRQ_MSK 9'h10c
`define IAP_A_LIST 9'h110
`define IAP_A_WMASK 9'h114
`define IAP_A_DONE_WT 9'h118
`define IAP_A_INPOS_WT 9'h11c
`define IAP_BEGIN_LSB 0
`define IAP_STOP_LSB 4
`define IAP_IRQ_ERR_BIT 4
`define IAP_RESP_OK 2'b00
`define IAP_RESP_ERR 2'b10
`define IAP_RST_TC 4'h0
`define IAP_RST_MSK 5'h00
`endif

// ===== rtl/iap_pkg.sv
/*
 Types of the independent axis profiler.
 Assumes the constants header is compiled alongside.
*/
package iap_pkg;
  typedef logic [8:0] iap_addr_t;
  typedef enum {RS_IDLE, RS_HOLD, RS_RESP} iap_rd_e;
endpackage

// ===== rtl/iap_profiler.sv
/*
 Independent point-to-point trajectory generator for up to four axes
 with an AXI4-Lite register slave and one level interrupt.
 Assumes SAMPLE_TICK is a one-cycle pulse per servo sample period and
 IN_POSITION comes from the servo loop, both synchronous to CLOCK.
*/
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "iap_params.svh"
module iap_profiler #(
  parameter int NAX = 4,
  parameter int VW = 16
) (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic SAMPLE_TICK,
  input wire logic [NAX-1:0] IN_POSITION,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire iap_pkg::iap_addr_t AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire iap_pkg::iap_addr_t ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic [NAX*32-1:0] CMD_POS,
  output logic [NAX-1:0] PROFILE_DONE,
  output logic IRQ
);
  import iap_pkg::*;

  if (NAX < 1 || NAX > 4 || VW < 2 || VW > 24) begin : g_bad
    $error("iap_profiler: NAX or VW out of range");
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  logic [31:0] target_q [NAX];
  logic [31:0] rel_q [NAX];
  logic [31:0] traj_q [NAX];
  logic [31:0] out_q [NAX];
  logic [VW-1:0] spd_q [NAX];
  logic [VW-1:0] acc_q [NAX];
  logic [VW-1:0] dec_q [NAX];
  logic [VW-1:0] vel_q [NAX];
  logic [3:0] tc_q [NAX];
  logic [NAX-1:0] mov_q, stop_q, relm_q, done_q, busy_d1_q;
  logic [31:0] traj_d [NAX];
  logic [31:0] out_d [NAX];
  logic [VW-1:0] vel_d [NAX];
  logic [NAX-1:0] fin, busy, w_hit, w_beg, w_stp, w_ref;
  logic aw_rdy_q, aw_have_q, w_rdy_q, w_have_q, bvalid_q;
  logic ar_rdy_q, rvalid_q;
  iap_addr_t awaddr_q, araddr_q;
  logic [31:0] wdata_q, rdata_q, rd_val;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  iap_rd_e rd_state_q;
  logic [4:0] irq_sts_q, irq_msk_q, irq_ev;
  logic irq_q;
  logic [NAX-1:0] list_q, wmask_q;
  logic wr_do, wr_ok, wt_ok, rd_take, done_clear, beg_req;
  logic [2:0] w_reg;
  logic [3:0] bmask;

  function automatic logic addr_ok(iap_addr_t a, logic wr);
    if (a[1:0] != 2'b00)
      return 1'b0;
    if (a[8])
      return a[7:0] <= `IAP_A_INPOS_WT - `IAP_A_CONTROL;
    return (int'(a[7:5]) < NAX) || (wr && a[7:5] == `IAP_LIST_AX);
  endfunction

  // ----------------------------------------------------------
  // Trajectory arithmetic
  // ----------------------------------------------------------
  logic [32:0] rem, mag, step, diff, sh;
  logic [63:0] lhs, rhs;
  logic [VW:0] v, vn, dcx, spx, acx;
  always_comb begin
    rem = '0;
    mag = '0;
    step = '0;
    diff = '0;
    sh = '0;
    lhs = '0;
    rhs = '0;
    v = '0;
    vn = '0;
    dcx = '0;
    spx = '0;
    acx = '0;
    for (int i = 0; i < NAX; i++) begin
      rem = {target_q[i][31], target_q[i]} - {traj_q[i][31], traj_q[i]};
      mag = rem[32] ? 33'(-rem) : rem;
      v = {1'b0, vel_q[i]};
      dcx = {1'b0, dec_q[i]};
      spx = {1'b0, spd_q[i]};
      acx = {1'b0, acc_q[i]};
      // Brake once the remaining distance only just covers the ramp
      lhs = 64'(v) * 64'(v + dcx);
      rhs = 64'(mag) * 64'({dec_q[i], 1'b0});
      if (stop_q[i] || (dcx != '0 && lhs >= rhs)) begin
        // Zero ramp-down has no ramp, so a stop halts at once
        vn = (dcx == '0 || v <= dcx) ? '0 : v - dcx;
      end else if (v > spx) begin
        vn = (v - spx > dcx) ? v - dcx : spx;
      end else begin
        vn = (v + acx > spx) ? spx : v + acx;
      end
      // Creep at one count so a zero speed cannot stall the move
      if (!stop_q[i] && vn == '0)
        vn = (VW+1)'(1);
      step = (33'(vn) > mag) ? mag : 33'(vn);
      fin[i] = stop_q[i] ? (vn == '0 || step == mag) : (step == mag);
      traj_d[i] = rem[32] ? traj_q[i] - step[31:0] :
                  traj_q[i] + step[31:0];
      vel_d[i] = fin[i] ? '0 : vn[VW-1:0];
      diff = {traj_q[i][31], traj_q[i]} - {out_q[i][31], out_q[i]};
      sh = 33'($signed(diff) >>> tc_q[i]);
      out_d[i] = (tc_q[i] == '0 || sh == '0) ? traj_q[i] :
                 out_q[i] + sh[31:0];
      busy[i] = mov_q[i] || (out_q[i] != traj_q[i]);
    end
  end

  // ----------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------
  assign wr_do = aw_have_q && w_have_q && !bvalid_q;
  assign wr_ok = wr_do && addr_ok(awaddr_q, 1'b1) && wstrb_q == 4'hf;
  assign w_reg = awaddr_q[4:2];
  assign bmask = wdata_q[`IAP_BEGIN_LSB+:4];
  // A write with any stop bit is a stop only, so it cannot begin all
  assign beg_req = wr_ok && awaddr_q == `IAP_A_CONTROL &&
                   wdata_q[`IAP_STOP_LSB+:4] == 4'h0;
  always_comb begin
    for (int i = 0; i < NAX; i++) begin
      w_hit[i] = wr_ok && !awaddr_q[8] &&
                 (int'(awaddr_q[7:5]) == i ||
                  (awaddr_q[7:5] == `IAP_LIST_AX && list_q[i]));
      w_beg[i] = beg_req && (bmask == 4'h0 || bmask[i]);
      w_stp[i] = wr_ok && awaddr_q == `IAP_A_CONTROL &&
                 wdata_q[`IAP_STOP_LSB+i];
      w_ref[i] = busy[i] && (w_beg[i] || (w_hit[i] &&
                 (w_reg == `IAP_R_ABS || w_reg == `IAP_R_REL ||
                  w_reg == `IAP_R_DEC)));
    end
  end

  // ----------------------------------------------------------
  // Axis state
  // ----------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      for (int i = 0; i < NAX; i++) begin
        target_q[i] <= '0;
        rel_q[i] <= '0;
        traj_q[i] <= '0;
        out_q[i] <= '0;
        spd_q[i] <= '0;
        acc_q[i] <= '0;
        dec_q[i] <= '0;
        vel_q[i] <= '0;
        tc_q[i] <= `IAP_RST_TC;
      end
      mov_q <= '0;
      stop_q <= '0;
      relm_q <= '0;
      done_q <= '0;
      busy_d1_q <= '0;
    end else begin
      busy_d1_q <= busy;
      done_q <= ~busy;
      for (int i = 0; i < NAX; i++) begin
        if (SAMPLE_TICK) begin
          out_q[i] <= out_d[i];
          if (mov_q[i]) begin
            traj_q[i] <= traj_d[i];
            vel_q[i] <= vel_d[i];
            if (fin[i]) begin
              mov_q[i] <= 1'b0;
              stop_q[i] <= 1'b0;
              if (stop_q[i])
                target_q[i] <= traj_d[i];
            end
          end
        end
        if (w_hit[i] && !w_ref[i]) begin
          unique case (w_reg)
            `IAP_R_ABS: begin
              target_q[i] <= wdata_q;
              relm_q[i] <= 1'b0;
            end
            `IAP_R_REL: begin
              rel_q[i] <= wdata_q;
              relm_q[i] <= 1'b1;
            end
            `IAP_R_SPD: spd_q[i] <= wdata_q[VW-1:0];
            `IAP_R_ACC: acc_q[i] <= wdata_q[VW-1:0];
            `IAP_R_DEC: dec_q[i] <= wdata_q[VW-1:0];
            `IAP_R_TC: tc_q[i] <= wdata_q[3:0];
            `IAP_R_INC: begin
              // Same direction is up to the host; reversal is unchecked
              if (busy[i]) begin
                target_q[i] <= target_q[i] + wdata_q;
                // Restart when only the smoothing tail was left
                mov_q[i] <= 1'b1;
              end else begin
                rel_q[i] <= wdata_q;
                relm_q[i] <= 1'b1;
                target_q[i] <= out_q[i] + wdata_q;
                mov_q[i] <= 1'b1;
                stop_q[i] <= 1'b0;
              end
            end
            `IAP_R_CPOS: ;
          endcase
        end
        if (w_stp[i] && mov_q[i])
          stop_q[i] <= 1'b1;
        if (w_beg[i] && !busy[i]) begin
          mov_q[i] <= 1'b1;
          stop_q[i] <= 1'b0;
          if (relm_q[i])
            target_q[i] <= out_q[i] + rel_q[i];
        end
      end
    end
  end

  for (genvar g = 0; g < NAX; g++) begin : g_pos
    assign CMD_POS[g*32+:32] = out_q[g];
  end
  assign PROFILE_DONE = done_q;

  chk_traj_step: assert property (
    mov_q[0] && SAMPLE_TICK && !stop_q[0] && target_q[0] != traj_q[0]
    |=> traj_q[0] != $past(traj_q[0]))
    else $error("trajectory did not advance on tick");
  // Zero cruise speed creeps at one count, above the cap by design
  chk_speed_cap: assert property (
    mov_q[0] && SAMPLE_TICK && spd_q[0] != '0 &&
    vel_q[0] <= spd_q[0] && $stable(spd_q[0]) |=>
    vel_q[0] <= $past(spd_q[0]))
    else $error("velocity above cruise speed");
  chk_stop_slow: assert property (
    stop_q[0] && mov_q[0] && SAMPLE_TICK |=> vel_q[0] <= $past(vel_q[0]))
    else $error("velocity rose while stopping");
  chk_done_final: assert property (
    $fell(busy[0]) |-> out_q[0] == target_q[0])
    else $error("profile ended off target");

  sequence s_begin_all;
    beg_req && bmask == 4'h0 && busy == '0;
  endsequence
  chk_begin_all: assert property (s_begin_all |=> &mov_q)
    else $error("empty begin mask did not start all");

  sequence s_incr_busy;
    w_hit[0] && w_reg == `IAP_R_INC && busy[0] &&
    !(SAMPLE_TICK && mov_q[0] && fin[0] && stop_q[0]);
  endsequence
  chk_incr_adds: assert property (s_incr_busy |=>
    target_q[0] == $past(target_q[0]) + $past(wdata_q))
    else $error("increment not added to target");

  sequence s_dec_moving;
    w_hit[0] && w_reg == `IAP_R_DEC && busy[0];
  endsequence
  chk_decel_refuse: assert property (s_dec_moving |=>
    dec_q[0] == $past(dec_q[0]) && irq_sts_q[`IAP_IRQ_ERR_BIT])
    else $error("decel change during motion accepted");

  // ----------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      aw_rdy_q <= 1'b0;
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
      w_rdy_q <= 1'b0;
      w_have_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= `IAP_RESP_OK;
    end else begin
      if (aw_rdy_q && AWVALID) begin
        aw_rdy_q <= 1'b0;
        aw_have_q <= 1'b1;
        awaddr_q <= AWADDR;
      end else if (!aw_have_q && !bvalid_q) begin
        aw_rdy_q <= 1'b1;
      end
      if (w_rdy_q && WVALID) begin
        w_rdy_q <= 1'b0;
        w_have_q <= 1'b1;
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
      end else if (!w_have_q && !bvalid_q) begin
        w_rdy_q <= 1'b1;
      end
      if (wr_do) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? `IAP_RESP_OK : `IAP_RESP_ERR;
      end else if (bvalid_q && BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign AWREADY = aw_rdy_q;
  assign WREADY = w_rdy_q;
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;

  // ----------------------------------------------------------
  // Global registers and interrupt
  // ----------------------------------------------------------
  assign irq_ev = {|w_ref, 4'(busy_d1_q & ~busy)};
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      irq_sts_q <= '0;
      irq_msk_q <= `IAP_RST_MSK;
      irq_q <= 1'b0;
      list_q <= '0;
      wmask_q <= '0;
    end else begin
      // New events win over the read that clears
      if (rd_take && araddr_q == `IAP_A_IRQ_STS)
        irq_sts_q <= irq_ev;
      else
        irq_sts_q <= irq_sts_q | irq_ev;
      irq_q <= |(irq_sts_q & irq_msk_q);
      if (wr_ok && awaddr_q == `IAP_A_IRQ_MSK)
        irq_msk_q <= wdata_q[4:0];
      if (wr_ok && awaddr_q == `IAP_A_LIST)
        list_q <= wdata_q[NAX-1:0];
      if (wr_ok && awaddr_q == `IAP_A_WMASK)
        wmask_q <= wdata_q[NAX-1:0];
    end
  end
  assign IRQ = irq_q;

  // ----------------------------------------------------------
  // AXI4-Lite read channels
  // ----------------------------------------------------------
  int ra;
  always_comb begin
    rd_val = '0;
    ra = (int'(araddr_q[7:5]) < NAX) ? int'(araddr_q[7:5]) : 0;
    if (!araddr_q[8]) begin
      unique case (araddr_q[4:2])
        `IAP_R_ABS: rd_val = busy[ra] ? target_q[ra] : out_q[ra];
        `IAP_R_REL: rd_val = rel_q[ra];
        `IAP_R_SPD: rd_val = 32'(spd_q[ra]);
        `IAP_R_ACC: rd_val = 32'(acc_q[ra]);
        `IAP_R_DEC: rd_val = 32'(dec_q[ra]);
        `IAP_R_TC: rd_val = 32'(tc_q[ra]);
        `IAP_R_INC: rd_val = '0;
        `IAP_R_CPOS: rd_val = out_q[ra];
      endcase
    end else if (araddr_q == `IAP_A_STATUS) begin
      rd_val = {24'h0, 4'(IN_POSITION), 4'(busy)};
    end else if (araddr_q == `IAP_A_IRQ_STS) begin
      rd_val = 32'(irq_sts_q);
    end else if (araddr_q == `IAP_A_IRQ_MSK) begin
      rd_val = 32'(irq_msk_q);
    end else if (araddr_q == `IAP_A_LIST) begin
      rd_val = 32'(list_q);
    end else if (araddr_q == `IAP_A_WMASK ||
                 araddr_q == `IAP_A_DONE_WT ||
                 araddr_q == `IAP_A_INPOS_WT) begin
      rd_val = 32'(wmask_q);
    end
  end

  // Wait reads stall the bus; a host that never sees the axis done hangs
  assign done_clear = (wmask_q & busy) == '0;
  assign wt_ok = araddr_q == `IAP_A_DONE_WT ? done_clear :
                 araddr_q == `IAP_A_INPOS_WT ?
                 (wmask_q & ~IN_POSITION) == '0 : 1'b1;
  assign rd_take = rd_state_q == RS_HOLD && wt_ok;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rd_state_q <= RS_IDLE;
      ar_rdy_q <= 1'b0;
      araddr_q <= '0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= `IAP_RESP_OK;
    end else begin
      unique case (rd_state_q)
        RS_IDLE: begin
          ar_rdy_q <= 1'b1;
          if (ar_rdy_q && ARVALID) begin
            ar_rdy_q <= 1'b0;
            araddr_q <= ARADDR;
            rd_state_q <= RS_HOLD;
          end
        end
        RS_HOLD: begin
          if (wt_ok) begin
            rvalid_q <= 1'b1;
            rdata_q <= addr_ok(araddr_q, 1'b0) ? rd_val : '0;
            rresp_q <= addr_ok(araddr_q, 1'b0) ? `IAP_RESP_OK :
                       `IAP_RESP_ERR;
            rd_state_q <= RS_RESP;
          end
        end
        RS_RESP: begin
          if (RREADY) begin
            rvalid_q <= 1'b0;
            rd_state_q <= RS_IDLE;
          end
        end
      endcase
    end
  end
  assign ARREADY = ar_rdy_q;
  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;

  chk_wait_hold: assert property ($rose(rvalid_q) &&
    araddr_q == `IAP_A_DONE_WT |-> $past(done_clear))
    else $error("done wait released early");
endmodule

// ===== tb/iap_servo_model.sv
/*
 Servo loop side of the profiler: makes the sample tick and reports
 each axis in position some time after its profile is done.
 Assumes one clock shared with the profiler.
*/
`timescale 1ns/1ps
module iap_servo_model #(
  parameter int TPER = 4,
  parameter int SETTLE = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] done,
  output logic tick,
  output logic [3:0] inpos
);
  int tc_q;
  int settle_q [4];
  always_ff @(posedge clk) begin
    tc_q <= (rst || tc_q == TPER - 1) ? 0 : tc_q + 1;
    tick <= !rst && tc_q == TPER - 1;
  end
  // Later axes settle slower, so waits see prompt and slow answers
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      settle_q[i] <= (rst || !done[i]) ? 0 :
                     settle_q[i] + (inpos[i] ? 0 : 1);
      inpos[i] <= !rst && done[i] && settle_q[i] >= SETTLE + 4 * i;
    end
  end
endmodule

// ===== tb/test_independent_axis_profiler.sv
/*
 Self-checking bench of the axis profiler over AXI4-Lite.
 Assumes the servo model drives the tick and in-position inputs.
*/
`timescale 1ns/1ps
`include "iap_params.svh"
module test_independent_axis_profiler;
  import iap_pkg::*;
  logic CLOCK = 0, SRST = 1, AWVALID = 0, WVALID = 0, BREADY = 0;
  logic ARVALID = 0, RREADY = 0;
  iap_addr_t AWADDR = '0, ARADDR = '0;
  logic [31:0] WDATA = '0, RDATA;
  logic [3:0] WSTRB = '0, IN_POSITION, PROFILE_DONE;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ, SAMPLE_TICK;
  logic [1:0] BRESP, RRESP, br, rr;
  logic [127:0] CMD_POS;
  logic [31:0] d, p, prev, sd, inc_v;
  int mismatches = 0, n_checks = 0, seed = 1562, maxstep, mon_ax;

  iap_profiler dut_u (.CLOCK(CLOCK), .SRST(SRST),
    .SAMPLE_TICK(SAMPLE_TICK), .IN_POSITION(IN_POSITION),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
    .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
    .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
    .CMD_POS(CMD_POS), .PROFILE_DONE(PROFILE_DONE), .IRQ(IRQ));
  iap_servo_model srv_u (.clk(CLOCK), .rst(SRST), .done(PROFILE_DONE),
    .tick(SAMPLE_TICK), .inpos(IN_POSITION));

  always #25 CLOCK = ~CLOCK;

  // Largest per-tick step of the watched axis
  always @(posedge CLOCK) begin
    if (SAMPLE_TICK) begin
      sd = CMD_POS[mon_ax*32+:32] - prev;
      if ($signed(sd) < 0) sd = -sd;
      if (sd > maxstep) maxstep = sd;
      prev = CMD_POS[mon_ax*32+:32];
    end
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] g, e, input string m);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk_resp(input logic [1:0] g, e, input string m);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %0t %s resp %b exp %b", $time, m, g, e);
    end
  endtask
  function automatic iap_addr_t ra(input int ax, input logic [2:0] r);
    return iap_addr_t'(ax * 32 + r * 4);
  endfunction
  function automatic logic [31:0] pos(input int ax);
    return CMD_POS[ax*32+:32];
  endfunction
  // Speed not reachable before braking must start
  function automatic bit tri_shape(input longint l, v, a, c);
    return v * v * (a + c) > 2 * a * c * l;
  endfunction

  task automatic wr(input iap_addr_t a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge CLOCK);
    AWVALID <= 1; AWADDR <= a; WVALID <= 1; WDATA <= v;
    WSTRB <= 4'hf; BREADY <= 1;
    do begin
      @(posedge CLOCK);
      n++;
      if (AWVALID === 1'b1 && AWREADY === 1'b1) AWVALID <= 0;
      if (WVALID === 1'b1 && WREADY === 1'b1) WVALID <= 0;
    end while (BVALID !== 1'b1 && n < 1000);
    br = BRESP;
    BREADY <= 0;
    if (n >= 1000) chk_resp(2'bxx, 2'b00, "write hang");
  endtask
  task automatic rd(input iap_addr_t a, output logic [31:0] v);
    int n;
    n = 0;
    @(posedge CLOCK);
    ARVALID <= 1; ARADDR <= a; RREADY <= 1;
    do begin
      @(posedge CLOCK);
      n++;
      if (ARVALID === 1'b1 && ARREADY === 1'b1) ARVALID <= 0;
    end while (RVALID !== 1'b1 && n < 20000);
    v = RDATA; rr = RRESP;
    RREADY <= 0;
    if (n >= 20000) chk_resp(2'bxx, 2'b00, "read hang");
  endtask
  task automatic wait_done(input logic [3:0] m);
    wr(`IAP_A_WMASK, {28'h0, m});
    rd(`IAP_A_DONE_WT, d);
  endtask

  task automatic move(input int ax, input logic [31:0] l, v, a, c,
                      input bit shp);
    logic [31:0] p0, q;
    p0 = pos(ax); q = pos((ax + 1) % 4); mon_ax = ax; prev = p0;
    wr(ra(ax, `IAP_R_SPD), v);
    wr(ra(ax, `IAP_R_ACC), a);
    wr(ra(ax, `IAP_R_DEC), c);
    wr(ra(ax, `IAP_R_REL), l);
    maxstep = 0;
    wr(`IAP_A_CONTROL, 32'h1 << ax);
    rd(ra(ax, `IAP_R_ABS), d);
    chk_word(d, p0 + l, "dest busy");
    wait_done(4'h1 << ax);
    chk_word(pos(ax), p0 + l, "final");
    chk_word(pos((ax + 1) % 4), q, "other axis");
    rd(ra(ax, `IAP_R_ACC), d);
    chk_word(d, a, "acc back");
    if (shp && tri_shape(l, v, a, c))
      chk_word(32'(maxstep < v), 1, "triangle");
    else if (shp)
      chk_word(maxstep, v, "trapezoid");
    $display("move axis %0d done", ax);
  endtask

  initial begin
    #(60000 * 50);
    mismatches++;
    $display("FAIL %0t watchdog", $time);
    close_out();
  end

  initial begin
    repeat (5) @(posedge CLOCK);
    SRST <= 0;
    for (int r = 1; r < 6; r++) begin
      rd(ra(0, 3'(r)), d);
      chk_word(d, 0, "reset value");
    end
    rd(`IAP_A_IRQ_MSK, d);
    chk_word(d, 0, "mask reset");
    chk_word(PROFILE_DONE, 4'hf, "idle done");
    rd(9'h120, d);
    chk_resp(rr, `IAP_RESP_ERR, "unmapped");
    wr(9'h102, 32'h5);
    chk_resp(br, `IAP_RESP_ERR, "misaligned");
    $display("test reset done");
    move(0, 100 + $unsigned($random(seed)) % 200, 100, 4, 4, 1);
    move(1, 600 + $unsigned($random(seed)) % 400, 20, 4, 4, 1);
    wr(ra(1, `IAP_R_TC), 2);
    move(1, 300, 15, 3, 3, 0);
    wr(ra(1, `IAP_R_TC), 0);
    // List write then begin with empty mask
    wr(`IAP_A_LIST, 4'hf);
    for (int r = 1; r < 5; r++) wr(ra(`IAP_LIST_AX, 3'(r)), r == 1 ? 40 : 2);
    p = pos(2);
    wr(`IAP_A_CONTROL, 0);
    wait_done(4'hf);
    chk_word(pos(2), p + 40, "all begin");
    rd(ra(3, `IAP_R_SPD), d);
    chk_word(d, 2, "list speed");
    rd(`IAP_A_INPOS_WT, d);
    chk_word(IN_POSITION[3], 1, "inpos wait");
    $display("test list done");
    // Long move: refusal, speed change, increment, stop
    wr(`IAP_A_IRQ_MSK, 32'h10);
    rd(`IAP_A_IRQ_STS, d);
    p = pos(0);
    wr(ra(0, `IAP_R_REL), 5000);
    wr(`IAP_A_CONTROL, 32'h1);
    wr(ra(0, `IAP_R_DEC), 9);
    repeat (3) @(posedge CLOCK);
    chk_word(IRQ, 1, "irq up");
    rd(ra(0, `IAP_R_DEC), d);
    chk_word(d, 2, "dec kept");
    wr(ra(0, `IAP_R_SPD), 30);
    rd(ra(0, `IAP_R_SPD), d);
    chk_word(d, 30, "speed live");
    rd(`IAP_A_IRQ_STS, d);
    chk_word(d & 32'h10, 32'h10, "refused flag");
    repeat (3) @(posedge CLOCK);
    chk_word(IRQ, 0, "irq cleared");
    wr(ra(0, `IAP_R_INC), 500);
    rd(ra(0, `IAP_R_ABS), d);
    chk_word(d, p + 5500, "incremented");
    wr(`IAP_A_CONTROL, 32'h10);
    wait_done(4'h1);
    chk_word(32'(pos(0) - p < 5500), 1, "stopped early");
    rd(ra(0, `IAP_R_ABS), d);
    chk_word(d, pos(0), "idle target");
    $display("test stop done");
    p = pos(3);
    inc_v = 1 + $unsigned($random(seed)) % 90;
    wr(ra(3, `IAP_R_INC), inc_v);
    wait_done(4'h8);
    chk_word(pos(3), p + inc_v, "idle inc");
    rd(ra(3, `IAP_R_REL), p);
    chk_word(p, inc_v, "inc as rel");
    $display("test increment done");
    close_out();
  end
endmodule
